// ### core/incr_file_skip_zero_exec.v
// Execution logic for increment-skip-if-zero and OR-literal instructions.
//
// Functional notes
// - Increment opcode reads file register, adds one.
// - Destination bit zero writes W, one writes file.
// - Zero result discards next instruction as NOP.
// - Non-zero result continues; instruction takes one cycle.
// - OR-literal ORs low-byte literal into W.
// - OR-literal writes W, single cycle, Q1-Q4.
// - Phases decode, read, process, write; skip idles.
`timescale 1ns/100ps
`include "exec_defs.vh"

module incr_file_skip_zero_exec
#(
    parameter IW = 14,
    parameter DW = 8,
    parameter AW = 7
)
(
    input  wire          CORE_CLK,
    input  wire          ARST_N,
    input  wire [IW-1:0] INSTR,
    input  wire [DW-1:0] FILE_RDATA,
    output reg  [AW-1:0] FILE_ADDR,
    output reg           FILE_RD,
    output reg           FILE_WR,
    output reg  [DW-1:0] FILE_WDATA,
    output reg  [DW-1:0] W_REG,
    output reg           Z_FLAG,
    output reg           SKIP_ACTIVE,
    output reg  [1:0]    PHASE
);

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    wire [1:0] phase;

    quarter_phase u_phase
    (
        .CORE_CLK (CORE_CLK),
        .ARST_N   (ARST_N),
        .phase_q  (phase)
    );

    // Phase decodes used by the per-phase stages below.
    wire in_q1;
    wire in_q2;
    wire in_q3;
    wire in_q4;

    assign in_q1 = (phase == `PH_Q1);
    assign in_q2 = (phase == `PH_Q2);
    assign in_q3 = (phase == `PH_Q3);
    assign in_q4 = (phase == `PH_Q4);

    // ------------------------------------------------------------
    // Instruction state
    // ------------------------------------------------------------
    reg [IW-1:0] ir_q;
    reg [DW-1:0] opnd_q;
    reg [DW-1:0] res_q;
    reg          is_inc_q;
    reg          is_or_q;
    reg          skip_next_q;

    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    wire [`OPC_HI-`OPC_LO:0] opc;
    wire                     opc_incr;
    wire                     opc_or;

    assign opc = INSTR[`OPC_HI:`OPC_LO];

    // A pending skip masks whatever opcode arrives in the discarded cycle,
    // so that cycle runs as a no-operation in all four phases.
    assign opc_incr = !skip_next_q && (opc == `OPC_INCR_SKIP);
    assign opc_or   = !skip_next_q && (opc == `OPC_OR_LIT);

    // ------------------------------------------------------------
    // Operand fields of the latched instruction
    // ------------------------------------------------------------
    wire [AW-1:0] file_sel;
    wire [DW-1:0] literal;
    wire          dest_file;

    assign file_sel  = ir_q[`FADDR_HI:`FADDR_LO];
    assign literal   = ir_q[`LIT_HI:`LIT_LO];
    assign dest_file = ir_q[`DEST_BIT];

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    wire [DW:0]   incr_sum;
    wire [DW-1:0] incr_res;
    wire [DW-1:0] or_res;
    wire          res_zero;

    // The carry out is dropped on purpose: an all-ones register wraps
    // to zero, which is what triggers the skip.
    assign incr_sum = {1'b0, FILE_RDATA} + {1'b0, `ONE8};
    assign incr_res = incr_sum[DW-1:0];

    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < DW; bit_i = bit_i + 1)
        begin : g_or_bit
            assign or_res[bit_i] = W_REG[bit_i] | opnd_q[bit_i];
        end
    endgenerate

    assign res_zero = (res_q == `ZERO8);

    // ------------------------------------------------------------
    // Per-phase actions
    // ------------------------------------------------------------
    wire rd_go;
    wire wr_file_go;
    wire wr_acc_inc_go;
    wire wr_acc_or_go;

    assign rd_go         = in_q2 && is_inc_q;
    assign wr_file_go    = in_q4 && is_inc_q && dest_file;
    assign wr_acc_inc_go = in_q4 && is_inc_q && !dest_file;
    assign wr_acc_or_go  = in_q4 && is_or_q;

    // ------------------------------------------------------------
    // Q1: decode and latch the instruction
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ir_q     <= `ZERO14;
            is_inc_q <= 1'b0;
            is_or_q  <= 1'b0;
        end
        else if (in_q1)
        begin
            ir_q     <= INSTR;
            is_inc_q <= opc_incr;
            is_or_q  <= opc_or;
        end
    end

    // ------------------------------------------------------------
    // Q2 and Q3: read the operand, then compute the result
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            opnd_q <= `ZERO8;
            res_q  <= `ZERO8;
        end
        else
        begin
            if (in_q2 && is_or_q)
                opnd_q <= literal;
            // File data answers the read strobe raised at the end of Q2.
            if (in_q3 && is_inc_q)
                res_q <= incr_res;
            else if (in_q3 && is_or_q)
                res_q <= or_res;
        end
    end

    // ------------------------------------------------------------
    // File register port
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            FILE_ADDR  <= `ZERO7;
            FILE_RD    <= 1'b0;
            FILE_WR    <= 1'b0;
            FILE_WDATA <= `ZERO8;
        end
        else
        begin
            // Both strobes last exactly one clock.
            FILE_RD <= rd_go;
            FILE_WR <= wr_file_go;
            if (rd_go)
                FILE_ADDR <= file_sel;
            if (wr_file_go)
                FILE_WDATA <= res_q;
        end
    end

    // ------------------------------------------------------------
    // Q4: working register and zero flag
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            W_REG  <= `ZERO8;
            Z_FLAG <= 1'b0;
        end
        else
        begin
            if (wr_acc_or_go)
                W_REG <= res_q;
            else if (wr_acc_inc_go)
                W_REG <= res_q;
            // Only the OR-literal result moves the flag; the increment
            // leaves every status flag as it was.
            if (wr_acc_or_go)
                Z_FLAG <= res_zero;
        end
    end

    // ------------------------------------------------------------
    // Skip control
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            skip_next_q <= 1'b0;
            SKIP_ACTIVE <= 1'b0;
        end
        else
        begin
            // The skip request is armed in Q4 and consumed in the next Q1.
            if (in_q4 && is_inc_q)
                skip_next_q <= res_zero;
            else if (in_q1)
                skip_next_q <= 1'b0;
            if (in_q1)
                SKIP_ACTIVE <= skip_next_q;
        end
    end

    // ------------------------------------------------------------
    // Phase output
    // ------------------------------------------------------------
    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            PHASE <= `PH_Q1;
        else
            PHASE <= phase;
    end

endmodule // incr_file_skip_zero_exec

// ### core/exec_defs.vh
// Opcode patterns, field positions and phase codes for the execution unit.
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

`define OPC_INCR_SKIP      6'h0F
`define OPC_OR_LIT         6'h38
`define OPC_HI             13
`define OPC_LO             8
`define DEST_BIT           7
`define FADDR_HI           6
`define FADDR_LO           0
`define LIT_HI             7
`define LIT_LO             0
`define ONE8               8'h01
`define ZERO8              8'h00
`define ZERO7              7'h00
`define ZERO14             14'h0000
`define PH_Q1              2'h0
`define PH_Q2              2'h1
`define PH_Q3              2'h2
`define PH_Q4              2'h3
`define PH_STEP            2'h1

`endif

// ### core/quarter_phase.v
// Quarter-phase sequencer producing Q1..Q4 of each instruction cycle.
`timescale 1ns/100ps
`include "exec_defs.vh"

module quarter_phase
(
    input  wire       CORE_CLK,
    input  wire       ARST_N,
    output reg  [1:0] phase_q
);

    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            phase_q <= `PH_Q1;
        else
            phase_q <= phase_q + `PH_STEP;
    end

endmodule // quarter_phase

// ### tb/exec_asserts.sv
// Checker for the increment-skip and OR-literal execution unit.
`timescale 1ns/100ps
`include "exec_defs.vh"
module exec_asserts
(
    input wire        CORE_CLK,
    input wire        ARST_N,
    input wire [13:0] INSTR,
    input wire [7:0]  FILE_RDATA,
    input wire [6:0]  FILE_ADDR,
    input wire        FILE_RD,
    input wire        FILE_WR,
    input wire [7:0]  FILE_WDATA,
    input wire [7:0]  W_REG,
    input wire        Z_FLAG,
    input wire        SKIP_ACTIVE,
    input wire [1:0]  PHASE
);
    wire [5:0] opc = INSTR[13:8];
    wire [7:0] lit = INSTR[7:0];
    wire       or_wb = PHASE == 2'h3 && !SKIP_ACTIVE;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    a_read_pulse: assert property (FILE_RD |=> !FILE_RD)
        else $error("read strobe too long");
    a_write_incr: assert property (FILE_WR |-> $past(FILE_RD, 2)
        && FILE_WDATA == 8'($past(FILE_RDATA, 2) + 8'h01))
        else $error("bad write data");
    a_skip_zero: assert property ($rose(SKIP_ACTIVE)
        |-> $past(FILE_RDATA, 3) == 8'hFF) else $error("bad skip");
    a_skip_len: assert property ($rose(SKIP_ACTIVE)
        |-> SKIP_ACTIVE[*4] ##1 !SKIP_ACTIVE) else $error("skip length");
    a_skip_idle: assert property (SKIP_ACTIVE |-> !FILE_RD)
        else $error("access in skip");
    a_no_skip: assert property (FILE_WR && FILE_WDATA != 8'h00
        |=> !SKIP_ACTIVE) else $error("skip on nonzero");
    a_z_only_or: assert property ($changed(Z_FLAG)
        |-> $past(opc, 4) == `OPC_OR_LIT) else $error("flag moved");
    a_or_result: assert property (
        or_wb && $past(opc, 4) == `OPC_OR_LIT
        |-> W_REG == ($past(W_REG) | $past(lit, 4))
        && Z_FLAG == (W_REG == 8'h00)) else $error("bad OR result");
    a_read_addr: assert property (
        FILE_RD |-> PHASE == 2'h1 && $past(opc, 2) == `OPC_INCR_SKIP
        && FILE_ADDR == $past(INSTR[6:0], 2))
        else $error("bad read address");
    a_write_phase: assert property (FILE_WR |-> PHASE == 2'h3)
        else $error("write out of phase");
endmodule // exec_asserts
bind incr_file_skip_zero_exec exec_asserts chk_u (.CORE_CLK(CORE_CLK),
    .ARST_N(ARST_N), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
    .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WR(FILE_WR),
    .FILE_WDATA(FILE_WDATA), .W_REG(W_REG), .Z_FLAG(Z_FLAG),
    .SKIP_ACTIVE(SKIP_ACTIVE), .PHASE(PHASE));

// ### tb/incr_file_skip_zero_exec_test.sv
// Self-checking bench for the increment-skip and OR-literal unit.
`timescale 1ns/100ps
module incr_file_skip_zero_exec_test;
    reg         CORE_CLK = 1'b0;
    reg         ARST_N = 1'b0;
    reg  [13:0] INSTR = 14'h0000;
    reg  [7:0]  FILE_RDATA = 8'h00;
    wire [6:0]  FILE_ADDR;
    wire        FILE_RD, FILE_WR, Z_FLAG, SKIP_ACTIVE;
    wire [7:0]  FILE_WDATA, W_REG;
    wire [1:0]  PHASE;
    integer     errors = 0;
    integer     checked = 0;
    always #5 CORE_CLK = ~CORE_CLK;
    incr_file_skip_zero_exec dut_u (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
        .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .FILE_ADDR(FILE_ADDR),
        .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .FILE_WDATA(FILE_WDATA),
        .W_REG(W_REG), .Z_FLAG(Z_FLAG), .SKIP_ACTIVE(SKIP_ACTIVE),
        .PHASE(PHASE));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            errors = errors + 1;
    end
    endtask
    // One instruction cycle; returns with the Q4 results settled.
    task run(input [13:0] i, input [7:0] rd);
    begin
        INSTR = i;
        FILE_RDATA = rd;
        repeat (4) @(negedge CORE_CLK);
    end
    endtask
    task t_skip;
    begin
        run(14'h0F00, 8'hFF);
        chk(W_REG, 8'h00);
        chk({7'h00, Z_FLAG}, 8'h00);
        run(14'h385A, 8'h00);
        chk({7'h00, SKIP_ACTIVE}, 8'h01);
        chk(W_REG, 8'h00);
    end
    endtask
    task t_write;
    begin
        run(14'h0F95, 8'h7F);
        chk({7'h00, FILE_WR}, 8'h01);
        chk(FILE_WDATA, 8'h80);
        chk({1'b0, FILE_ADDR}, 8'h15);
        run(14'h3801, 8'h00);
        chk(W_REG, 8'h01);
    end
    endtask
    task t_or;
    begin
        run(14'h389A, 8'h00);
        run(14'h3835, 8'h00);
        chk(W_REG, 8'hBF);
        chk({7'h00, Z_FLAG}, 8'h00);
    end
    endtask
    // Looks inside one increment cycle at the read strobe and phase.
    task t_read;
    begin
        INSTR = 14'h0F2A;
        FILE_RDATA = 8'h10;
        repeat (2) @(negedge CORE_CLK);
        chk({7'h00, FILE_RD}, 8'h01);
        chk({1'b0, FILE_ADDR}, 8'h2A);
        repeat (2) @(negedge CORE_CLK);
        chk({7'h00, FILE_RD}, 8'h00);
        chk(W_REG, 8'h11);
        chk({6'h00, PHASE}, 8'h03);
    end
    endtask
    task t_flag;
    begin
        run(14'h0F00, 8'hFF);
        run(14'h3800, 8'h00);
        chk({7'h00, SKIP_ACTIVE}, 8'h01);
        run(14'h3800, 8'h00);
        chk({7'h00, Z_FLAG}, 8'h01);
        run(14'h0F80, 8'hFF);
        chk(FILE_WDATA, 8'h00);
        chk({7'h00, Z_FLAG}, 8'h01);
        run(14'h38FF, 8'h00);
        chk(W_REG, 8'h00);
        run(14'h0EB3, 8'h41);
        chk({7'h00, FILE_WR}, 8'h00);
        chk(W_REG, 8'h00);
    end
    endtask
    task end_sim;
    begin
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    initial
    begin
        #2000;
        errors = errors + 1;
        end_sim;
    end
    initial
    begin
        repeat (2) @(negedge CORE_CLK);
        ARST_N = 1'b1;
        t_skip;
        t_write;
        t_or;
        t_read;
        t_flag;
        end_sim;
    end
endmodule // incr_file_skip_zero_exec_test
